// ===== hw/csb_params.svh
/*
  timing counts, field positions and reset values of the cell/packet system bus block.
  assumes it is included by bare name inside the package or at the top of a later file.
*/
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

`define CSB_CLK_PERIOD_NS   20
`define CSB_DATA_W          16
`define CSB_ADDR_W          5
`define CSB_GAP_W           8
`define CSB_BYTE_HI_MSB     15
`define CSB_BYTE_HI_LSB     8
`define CSB_BYTE_LO_MSB     7
`define CSB_MOD_ALL         1'b0
`define CSB_MOD_UPPER       1'b1
`define CSB_RST_DATA        16'h0000
`define CSB_RST_GAP         8'h00
`define CSB_RST_ADDR        5'h00

`endif

// ===== hw/csb_pkg.sv
/*
  types shared by the receive engine and the transmit sampler.
  assumes csb_params.svh is reachable on the include path.
*/
package csb_pkg;
`include "csb_params.svh"

    typedef enum logic [1:0] {
        CSB_MODE_CELL,
        CSB_MODE_PKT_L2,
        CSB_MODE_PKT_L3
    } csb_mode_e;

    typedef enum logic [1:0] {
        CSB_RX_IDLE,
        CSB_RX_SEND,
        CSB_RX_HOLD,
        CSB_RX_GAP
    } csb_rx_e;

    typedef logic [`CSB_DATA_W-1:0] csb_data_t;

    typedef struct packed {
        csb_data_t data;
        logic      sop;
        logic      eop;
        logic      mod;
        logic      err;
    } csb_rx_word_s;

    typedef struct packed {
        csb_data_t             data;
        logic                  par;
        logic [`CSB_ADDR_W-1:0] addr;
        logic                  en_n;
    } csb_tx_pins_s;

    typedef struct packed {
        csb_data_t             data;
        logic [`CSB_ADDR_W-1:0] addr;
        logic                  write;
        logic                  par_err;
        logic                  upper_err;
    } csb_tx_word_s;

endpackage

// ===== hw/csb_tx_sample.sv
/*
  transmit side sampler: registers the link-layer data, parity, port address and enable.
  assumes the transmit pins are synchronous to CLK_I, which doubles as the transmit clock.
*/
`timescale 1ns/100ps
`include "csb_params.svh"

module csb_tx_sample
    import csb_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    input  wire logic         bus8_i,
    input  wire logic         parity_odd_i,
    input  wire csb_tx_pins_s pins_i,
    output csb_tx_word_s      word_o
);

    typedef struct packed {
        csb_tx_word_s word;
    } csb_tx_state_s;

    csb_tx_state_s st;
    csb_tx_state_s next_st;
    logic          calc_par;
    logic          upper_set;

    always_comb begin
        next_st = st;
        // even parity sums to zero with the parity bit, odd sums to one
        calc_par  = ^pins_i.data ^ parity_odd_i;
        upper_set = |pins_i.data[`CSB_BYTE_HI_MSB:`CSB_BYTE_HI_LSB];
        // sampled on every rising edge, no qualification on the enable
        next_st.word.write = ~pins_i.en_n;                              // R14 R18
        next_st.word.addr  = pins_i.addr;                               // R17
        next_st.word.data  = bus8_i ? {8'h00, pins_i.data[`CSB_BYTE_LO_MSB:0]} : pins_i.data; // R15
        // errors only mean something on a cycle that transfers
        next_st.word.par_err   = ~pins_i.en_n & (calc_par != pins_i.par); // R16
        next_st.word.upper_err = ~pins_i.en_n & bus8_i & upper_set;       // R15
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            st.word.data      <= `CSB_RST_DATA;
            st.word.addr      <= `CSB_RST_ADDR;
            st.word.write     <= 1'b0;
            st.word.par_err   <= 1'b0;
            st.word.upper_err <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign word_o = st.word;

endmodule

// ===== hw/csb_sys_bus.sv
/*
  cell/packet system bus: receive data-valid, modulus and error engine plus the transmit sampler.
  assumes one clock CLK_I for both directions, all inputs synchronous to it, and a port FIFO
  whose head word is shown on FIFO_HEAD_I and advances one edge after FIFO_POP_O is seen high.
*/
// Notes on behaviour
// R1: with valid high, data, parity, start, end, modulus and error are valid; transfer counts.
// R2: with valid low the receive data group carries nothing and nothing transfers.
// R3: valid, modulus and error change only on the rising receive clock edge.
// R4: valid rises only for a selected port holding a block or a whole packet end.
// R5: level 2: valid drops on empty, packet end or read enable off; low until enable off.
// R6: level 3: valid drops on empty, or at end when gap nonzero; stays low that long.
// R7: cell mode keeps valid permanently low.
// R8: modulus zero means all sixteen bits valid, one means upper byte only.
// R9: modulus only means something alongside end of packet; link layer ignores it otherwise.
// R10: cell mode or eight-bit packet mode keeps modulus low.
// R11: error high marks the current packet as corrupt; link layer aborts it.
// R12: link layer samples error only with end of packet; cell mode keeps it low.
// R13: link layer keeps the transmit clock at or below 52 MHz.
// R14: transmit data, parity, address and enable are sampled on the rising transmit edge.
// R15: eight-bit mode uses bits 7 to 0; link layer holds bits 15 to 8 low.
// R16: link layer drives transmit parity to match the transmit data bus.
// R17: link layer picks a port with the five-bit transmit address, bit 0 lowest.
// R18: transmit enable is active low; low transfers a word, high transfers none.
// R19: end of packet rises on the last transfer of each packet, at the rising edge.
// R20: level 3: while the in-band address strobe is high, valid stays low.
// R21: error rises only together with end of packet and with valid high.
`timescale 1ns/100ps
`include "csb_params.svh"

module csb_sys_bus
    import csb_pkg::*;
(
    input  wire logic                   CLK_I,
    input  wire logic                   RSTN_I,
    input  wire csb_mode_e              MODE_I,
    input  wire logic                   BUS8_I,
    input  wire logic                   PARITY_ODD_I,
    input  wire logic [`CSB_GAP_W-1:0]  MIN_DEASSERT_I,
    input  wire logic                   PORT_SELECTED_I,
    input  wire logic                   FIFO_BLOCK_READY_I,
    input  wire logic                   FIFO_EMPTY_I,
    input  wire csb_rx_word_s           FIFO_HEAD_I,
    input  wire logic                   RX_READ_ENABLE_N_I,
    input  wire logic                   RX_INBAND_ADDRESS_STROBE_I,
    input  wire csb_tx_pins_s           TX_PINS_I,
    output logic                        FIFO_POP_O,
    output logic                        RX_VALID_OUT_O,
    output csb_data_t                   RX_DATA_BUS_O,
    output logic                        RX_PARITY_OUT_O,
    output logic                        RX_START_OF_UNIT_O,
    output logic                        RX_END_OF_PACKET_O,
    output logic                        RX_BYTE_MODULUS_O,
    output logic                        RX_PACKET_ERROR_O,
    output logic                        RX_HOLD_O,
    output csb_tx_word_s                TX_WORD_O
);

    typedef struct packed {
        csb_rx_e               fsm;
        logic [`CSB_GAP_W-1:0] gap;
        logic                  valid;
        csb_rx_word_s          word;
        logic                  par;
        logic                  pop;
        logic                  hold;
    } csb_rx_state_s;

    csb_rx_state_s st;
    csb_rx_state_s next_st;

    logic is_cell;
    logic is_l2;
    logic is_l3;
    logic ren;
    logic strobe_block;
    logic can_start;
    logic can_take;
    logic take;
    logic gap_set;

    always_comb begin
        is_cell      = (MODE_I == CSB_MODE_CELL);
        is_l2        = (MODE_I == CSB_MODE_PKT_L2);
        is_l3        = (MODE_I == CSB_MODE_PKT_L3);
        ren          = ~RX_READ_ENABLE_N_I;
        gap_set      = (MIN_DEASSERT_I != `CSB_RST_GAP);
        // the address strobe cycle belongs to the address, never to data
        strobe_block = is_l3 & RX_INBAND_ADDRESS_STROBE_I;          // R20
        // a new burst needs a selected port with a block or a packet end waiting
        can_start    = PORT_SELECTED_I & FIFO_BLOCK_READY_I & ~FIFO_EMPTY_I; // R4
        // the head word is stale in the cycle after a pop, so skip that cycle;
        // this halves the peak rate but needs no lookahead from the FIFO
        can_take     = ~FIFO_EMPTY_I & ~st.pop & ~strobe_block & ren;
        take         = 1'b0;
        next_st      = st;
        next_st.valid = 1'b0;                                        // R2
        next_st.pop   = 1'b0;
        next_st.word  = '0;                                          // R2
        next_st.par   = 1'b0;

        case (st.fsm)
            CSB_RX_IDLE: begin
                if (!is_cell && can_start && !strobe_block && ren) begin // R4
                    next_st.fsm = CSB_RX_SEND;
                end
            end
            CSB_RX_SEND: begin
                if (is_l2 && !ren) begin
                    // enable already off, so the hold ends at once
                    next_st.fsm = CSB_RX_IDLE;                       // R5
                end else if (FIFO_EMPTY_I && !st.pop) begin
                    if (is_l2) begin
                        next_st.fsm = CSB_RX_HOLD;                   // R5
                    end else if (gap_set) begin
                        next_st.fsm = CSB_RX_GAP;                    // R6
                        next_st.gap = MIN_DEASSERT_I;
                    end else begin
                        next_st.fsm = CSB_RX_IDLE;                   // R6
                    end
                end else if (can_take) begin
                    take = 1'b1;
                    if (FIFO_HEAD_I.eop) begin
                        if (is_l2) begin
                            next_st.fsm = CSB_RX_HOLD;               // R5
                        end else if (gap_set) begin
                            next_st.fsm = CSB_RX_GAP;                // R6
                            next_st.gap = MIN_DEASSERT_I;
                        end else begin
                            next_st.fsm = CSB_RX_IDLE;
                        end
                    end
                end
            end
            CSB_RX_HOLD: begin
                // level 2 keeps valid low until the link layer lets go of the enable
                if (!ren) begin
                    next_st.fsm = CSB_RX_IDLE;                       // R5
                end
            end
            CSB_RX_GAP: begin
                if (st.gap <= 8'h01) begin
                    next_st.gap = `CSB_RST_GAP;
                    next_st.fsm = CSB_RX_IDLE;                       // R6
                end else begin
                    next_st.gap = st.gap - 8'h01;                    // R6
                end
            end
            default: begin
                next_st.fsm = CSB_RX_IDLE;
            end
        endcase

        // a mode change to cells mid-burst abandons the burst cleanly
        if (is_cell) begin
            take        = 1'b0;
            next_st.fsm = CSB_RX_IDLE;                               // R7
            next_st.gap = `CSB_RST_GAP;
        end

        if (take) begin
            next_st.valid    = 1'b1;                                 // R1
            next_st.pop      = 1'b1;
            next_st.word.sop = FIFO_HEAD_I.sop;                      // R1
            next_st.word.eop = FIFO_HEAD_I.eop;                      // R19
            if (BUS8_I) begin
                next_st.word.data = {8'h00, FIFO_HEAD_I.data[`CSB_BYTE_LO_MSB:0]};
            end else begin
                next_st.word.data = FIFO_HEAD_I.data;                // R1
            end
            // modulus only carries meaning on the last word of a wide packet
            if (!BUS8_I && FIFO_HEAD_I.eop) begin
                next_st.word.mod = FIFO_HEAD_I.mod;                  // R8 R9 R10
            end else begin
                next_st.word.mod = `CSB_MOD_ALL;                     // R10
            end
            // error is tied to the last transfer so it cannot leak mid-packet
            next_st.word.err = FIFO_HEAD_I.eop & FIFO_HEAD_I.err;    // R11 R21
            next_st.par = ^next_st.word.data ^ PARITY_ODD_I;         // R1
        end
        // registered so the pin comes from a flip-flop; stays low on the last word itself
        next_st.hold = ((next_st.fsm == CSB_RX_HOLD) | (next_st.fsm == CSB_RX_GAP)) & ~take; // R5 R6
    end

    // all receive outputs move only on this edge
    always_ff @(posedge CLK_I) begin                                 // R3
        if (!RSTN_I) begin
            st.fsm   <= CSB_RX_IDLE;
            st.gap   <= `CSB_RST_GAP;
            st.valid <= 1'b0;
            st.word  <= '0;
            st.par   <= 1'b0;
            st.pop   <= 1'b0;
            st.hold  <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // every output below is a flip-flop of the state record
    assign FIFO_POP_O         = st.pop;
    assign RX_VALID_OUT_O     = st.valid;                            // R1 R7
    assign RX_DATA_BUS_O      = st.word.data;
    assign RX_PARITY_OUT_O    = st.par;
    assign RX_START_OF_UNIT_O = st.word.sop;
    assign RX_END_OF_PACKET_O = st.word.eop;                         // R19
    assign RX_BYTE_MODULUS_O  = st.word.mod;                         // R8
    assign RX_PACKET_ERROR_O  = st.word.err;                         // R12 R21
    assign RX_HOLD_O          = st.hold;                             // R5 R6

    // transmit pins are sampled by the companion module on the same clock;
    // that clock is assumed to stay within the link-layer limit
    csb_tx_sample u_tx (                                             // R13 R14
        .clk_i        (CLK_I),
        .rstn_i       (RSTN_I),
        .bus8_i       (BUS8_I),
        .parity_odd_i (PARITY_ODD_I),
        .pins_i       (TX_PINS_I),
        .word_o       (TX_WORD_O)
    );

endmodule

// ===== test/csb_sys_bus_properties.sv
/*
  checker on the receive outputs of csb_sys_bus, bound to the top module.
  assumes CLK_I and the synchronous active-low RSTN_I.
*/
`timescale 1ns/100ps
`include "csb_params.svh"
module csb_sys_bus_props
    import csb_pkg::*;
(
    input wire logic                  CLK_I,
    input wire logic                  RSTN_I,
    input wire csb_mode_e             MODE_I,
    input wire logic                  BUS8_I,
    input wire logic [`CSB_GAP_W-1:0] MIN_DEASSERT_I,
    input wire logic                  RX_READ_ENABLE_N_I,
    input wire logic                  RX_INBAND_ADDRESS_STROBE_I,
    input wire logic                  RX_VALID_OUT_O,
    input wire logic                  RX_END_OF_PACKET_O,
    input wire logic                  RX_BYTE_MODULUS_O,
    input wire logic                  RX_PACKET_ERROR_O,
    input wire logic                  RX_HOLD_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RSTN_I);
    // saturates so a long idle never wraps back below the gap
    logic [8:0] low_cnt;
    logic       after_eop;
    always_ff @(posedge CLK_I) begin
        if (!RSTN_I || RX_VALID_OUT_O) begin
            low_cnt <= 9'h000;
        end else if (low_cnt != 9'h1ff) begin
            low_cnt <= low_cnt + 9'h001;
        end
        if (!RSTN_I) begin
            after_eop <= 1'b0;
        end else if (RX_VALID_OUT_O) begin
            after_eop <= RX_END_OF_PACKET_O;
        end
    end
    a_cell_valid: assert property (MODE_I == CSB_MODE_CELL && $stable(MODE_I) |-> !RX_VALID_OUT_O)
        else $error("valid in cell mode");
    a_mod_held_low: assert property (
        (MODE_I == CSB_MODE_CELL && $stable(MODE_I) || BUS8_I && $stable(BUS8_I)) |-> !RX_BYTE_MODULUS_O)
        else $error("modulus not low");
    a_mod_with_eop: assert property (RX_BYTE_MODULUS_O |-> RX_END_OF_PACKET_O && RX_VALID_OUT_O)
        else $error("modulus without end");
    a_err_with_eop: assert property (RX_PACKET_ERROR_O |-> RX_END_OF_PACKET_O && RX_VALID_OUT_O)
        else $error("error without end");
    a_hold_no_valid: assert property (RX_HOLD_O |-> !RX_VALID_OUT_O)
        else $error("valid during hold");
    a_l2_hold_kept: assert property (
        MODE_I == CSB_MODE_PKT_L2 && RX_HOLD_O && !RX_READ_ENABLE_N_I |=> RX_HOLD_O)
        else $error("hold left early");
    a_strobe_blocks: assert property (
        MODE_I == CSB_MODE_PKT_L3 && $past(RX_INBAND_ADDRESS_STROBE_I) |-> !RX_VALID_OUT_O)
        else $error("valid after strobe");
    a_l3_gap_len: assert property (
        MODE_I == CSB_MODE_PKT_L3 && after_eop && $rose(RX_VALID_OUT_O) |-> low_cnt >= MIN_DEASSERT_I)
        else $error("gap too short");
endmodule
bind csb_sys_bus csb_sys_bus_props u_props (.*);

// ===== test/csb_link_model.sv
/*
  link-layer model: takes receive words while valid is high, drives the transmit pins.
  assumes the clock shared with the block; it changes its outputs 1 ns after the rising edge.
*/
`timescale 1ns/100ps
module csb_link_model
    import csb_pkg::*;
(
    input  wire logic         clk_i,
    input  wire logic         valid_i,
    input  wire csb_rx_word_s word_i,
    input  wire logic         par_i,
    input  wire logic         parity_odd_i,
    output logic              ren_n_o,
    output csb_tx_pins_s      pins_o
);
    csb_rx_word_s got[$];
    int           par_bad = 0;
    initial begin
        ren_n_o = 1'b1;
        pins_o  = 23'h000001;
    end
    // mid-cycle sampling keeps clear of the edge that updates the outputs
    always @(negedge clk_i) begin
        if (valid_i === 1'b1) begin
            got.push_back({word_i.data, word_i.sop, word_i.eop,
                           word_i.mod & word_i.eop, word_i.err & word_i.eop});
            if (par_i !== (^word_i.data ^ parity_odd_i)) par_bad++;
        end
    end
    task automatic set_ren(input logic v);
        @(posedge clk_i);
        #1 ren_n_o = v;
    endtask
    // an idle bus shows the inverted last word, never a stale copy
    task automatic send(input csb_data_t d, input logic [4:0] a, input logic en_n, input logic flip);
        @(posedge clk_i);
        #1 pins_o = {(en_n ? ~pins_o.data : d), ^d ^ parity_odd_i ^ flip, a, en_n};
    endtask
endmodule

// ===== test/csb_sys_bus_tb_top.sv
/*
  self-checking bench for csb_sys_bus; a queue stands in for the port fifo.
  assumes the design files and csb_link_model are compiled first.
*/
`timescale 1ns/100ps
`include "csb_params.svh"
module csb_sys_bus_tb_top
    import csb_pkg::*;
;
    // names match the design's ports so the instance connects by name
    logic                  CLK_I = 1'b0;
    logic                  RSTN_I = 1'b0;
    csb_mode_e             MODE_I = CSB_MODE_CELL;
    logic                  BUS8_I = 1'b0;
    logic                  PARITY_ODD_I = 1'b0;
    logic [`CSB_GAP_W-1:0] MIN_DEASSERT_I = 8'h00;
    logic                  PORT_SELECTED_I = 1'b0;
    logic                  FIFO_BLOCK_READY_I = 1'b0;
    logic                  FIFO_EMPTY_I = 1'b1;
    csb_rx_word_s          FIFO_HEAD_I = '0;
    logic                  RX_INBAND_ADDRESS_STROBE_I = 1'b0;
    logic                  RX_READ_ENABLE_N_I, FIFO_POP_O, RX_VALID_OUT_O, RX_PARITY_OUT_O;
    logic                  RX_START_OF_UNIT_O, RX_END_OF_PACKET_O, RX_BYTE_MODULUS_O, RX_PACKET_ERROR_O, RX_HOLD_O;
    csb_tx_pins_s          TX_PINS_I;
    csb_data_t             RX_DATA_BUS_O;
    csb_tx_word_s          TX_WORD_O;
    csb_rx_word_s          fq[$], exp_q[$];
    logic                  pop_q;
    int                    n_mismatch, compares, cycles;
    csb_sys_bus dut (.*);
    csb_link_model lp (
        .clk_i        (CLK_I),
        .valid_i      (RX_VALID_OUT_O),
        .word_i       ({RX_DATA_BUS_O, RX_START_OF_UNIT_O, RX_END_OF_PACKET_O,
                        RX_BYTE_MODULUS_O, RX_PACKET_ERROR_O}),
        .par_i        (RX_PARITY_OUT_O),
        .parity_odd_i (PARITY_ODD_I),
        .ren_n_o      (RX_READ_ENABLE_N_I),
        .pins_o       (TX_PINS_I)
    );
    initial begin
        forever #10 CLK_I = ~CLK_I;
    end
    always @(negedge CLK_I) pop_q <= FIFO_POP_O;
    always @(posedge CLK_I) begin
        #1;
        if (pop_q === 1'b1 && fq.size() > 0) void'(fq.pop_front());
        FIFO_EMPTY_I = (fq.size() == 0);
        FIFO_BLOCK_READY_I = (fq.size() != 0);
        FIFO_HEAD_I = fq.size() ? fq[0] : ~FIFO_HEAD_I;
    end
    always @(posedge CLK_I) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic test_done();
        if (n_mismatch == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK_I);
        #1;
    endtask
    task automatic push(input csb_rx_word_s w, input csb_rx_word_s e);
        fq.push_back(w);
        exp_q.push_back(e);
    endtask
    task automatic rx_go(input csb_mode_e m);
        MODE_I = m;
        PORT_SELECTED_I = 1'b1;
        lp.set_ren(1'b0);
    endtask
    task automatic rx_expect(input int n);
        for (int i = 0; i < 300 && lp.got.size() < n; i++) cyc(1);
        for (int i = 0; i < n; i++) chk(lp.got[i], exp_q[i]);
        chk(lp.got.size(), n);
        chk(lp.par_bad, 0);
    endtask
    task automatic rx_end();
        lp.set_ren(1'b1);
        PORT_SELECTED_I = 1'b0;
        cyc(8);
        fq.delete();
        exp_q.delete();
        lp.got.delete();
    endtask
    task automatic s_cell_unselected();
        push(20'h11118, 20'h11118);
        push(20'h22224, 20'h22224);
        rx_go(CSB_MODE_CELL);
        cyc(20);
        chk(lp.got.size(), 0);
        MODE_I = CSB_MODE_PKT_L2;
        PORT_SELECTED_I = 1'b0;
        cyc(20);
        chk(lp.got.size(), 0);
        PORT_SELECTED_I = 1'b1;
        rx_expect(2);
        rx_end();
    endtask
    task automatic s_l2_hold();
        push(20'h12348, 20'h12348);
        push(20'h56780, 20'h56780);
        push(20'habcd7, 20'habcd7);
        push(20'h0f0fc, 20'h0f0fc);
        rx_go(CSB_MODE_PKT_L2);
        rx_expect(3);
        cyc(10);
        chk(RX_HOLD_O, 1);
        chk(lp.got.size(), 3);
        lp.set_ren(1'b1);
        lp.set_ren(1'b0);
        rx_expect(4);
        rx_end();
    endtask
    task automatic s_l3_gap();
        MIN_DEASSERT_I = 8'h04;
        PARITY_ODD_I = 1'b1;
        RX_INBAND_ADDRESS_STROBE_I = 1'b1;
        push(20'h1aaa8, 20'h1aaa8);
        push(20'h1bbb4, 20'h1bbb4);
        push(20'h2ccc8, 20'h2ccc8);
        push(20'h2ddd7, 20'h2ddd7);
        rx_go(CSB_MODE_PKT_L3);
        cyc(6);
        chk(lp.got.size(), 0);
        RX_INBAND_ADDRESS_STROBE_I = 1'b0;
        rx_expect(4);
        rx_end();
    endtask
    task automatic s_bus8();
        BUS8_I = 1'b1;
        push(20'hff5ae, 20'h005ac);
        rx_go(CSB_MODE_PKT_L2);
        rx_expect(1);
        rx_end();
    endtask
    task automatic tx_case(input csb_data_t d, input logic [4:0] a, input logic en_n, input logic flip);
        lp.send(d, a, en_n, flip);
        cyc(1);
        chk({TX_WORD_O.write, TX_WORD_O.par_err}, {!en_n, !en_n & flip});
        chk(TX_WORD_O.upper_err, !en_n & BUS8_I & (|d[15:8]));
        if (!en_n) chk({TX_WORD_O.addr, TX_WORD_O.data}, {a, BUS8_I ? {8'h00, d[7:0]} : d});
    endtask
    task automatic s_tx();
        tx_case(16'h00ff, 5'h10, 1'b0, 1'b0);
        tx_case(16'h1280, 5'h00, 1'b0, 1'b0);
        BUS8_I = 1'b0;
        tx_case(16'ha5c3, 5'h1f, 1'b0, 1'b1);
        PARITY_ODD_I = 1'b0;
        tx_case(16'h0001, 5'h01, 1'b0, 1'b0);
        tx_case(16'h7777, 5'h0a, 1'b1, 1'b0);
    endtask
    initial begin
        cyc(16);
        RSTN_I = 1'b1;
        cyc(1);
        chk({RX_VALID_OUT_O, FIFO_POP_O, RX_HOLD_O, TX_WORD_O}, 0);
        s_cell_unselected();
        s_l2_hold();
        s_l3_gap();
        s_bus8();
        s_tx();
        test_done();
    end
endmodule
